// ===== rtl/hspt_pkg.sv
/*
  hspt_pkg: shared constants of the high-speed pwm timer block.
  register indices on the 8-bit cpu register port, bit positions,
  reset values and widths. assumes the module refers to every name
  as hspt_pkg::name.
*/
package hspt_pkg;
  // widths
  localparam int CNT_W = 10;                   // counter width
  localparam int CMP_W = 11;                   // compare width, enhanced
  localparam int ADR_W = 3;                    // register index width

  // register indices
  localparam logic [2:0] ADR_CTRL_D = 3'h0;    // fault_and_waveform_control
  localparam logic [2:0] ADR_CTRL_E = 3'h1;    // update_lock_and_override
  localparam logic [2:0] ADR_CNT    = 3'h2;    // counter_low_byte
  localparam logic [2:0] ADR_HTMP   = 3'h3;    // shared_high_bits_temp
  localparam logic [2:0] ADR_CMPA   = 3'h4;    // compare_a_value
  localparam logic [2:0] ADR_CMPB   = 3'h5;    // compare_b_value
  localparam logic [2:0] ADR_CMPC   = 3'h6;    // top_compare_value
  localparam logic [2:0] ADR_FLAGS  = 3'h7;    // match and overflow flags

  // control d bit positions
  localparam int B_FIRQ_EN = 7;                // fault_irq_enable
  localparam int B_FMODE   = 6;                // fault_mode_enable
  localparam int B_FNOISE  = 5;                // fault_noise_filter_enable
  localparam int B_FEDGE   = 4;                // fault_edge_select
  localparam int B_FCOMP   = 3;                // fault_comparator_source
  localparam int B_FFLAG   = 2;                // fault_flag
  localparam int B_WGM_HI  = 1;                // waveform_mode_high
  localparam int B_WGM_LO  = 0;                // waveform_mode_low

  // control e bit positions
  localparam int B_LOCK    = 7;                // compare_update_lock
  localparam int B_ENH     = 6;                // enhanced_resolution_enable

  // flags register bit positions
  localparam int B_OVF     = 0;                // overflow_flag
  localparam int B_MB      = 1;                // match_b_flag
  localparam int B_MA      = 2;                // match_a_flag

  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [9:0]  CNT_RST  = 10'h000;
  localparam logic [10:0] CMP_RST  = 11'h000;
  localparam logic [9:0]  TOP_RST  = 10'h0ff;
  localparam logic [9:0]  TOP_MIN  = 10'h003;  // smallest accepted top
  localparam logic [9:0]  CNT_BOT  = 10'h000;  // bottom value
  localparam logic [9:0]  CNT_ONE  = 10'h001;
  localparam logic [3:0]  FILT_ALL = 4'hf;     // four equal samples

  // counting direction, one-hot
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } hspt_dir_t;
endpackage

// ===== rtl/hspt_timer.sv
/*
  hspt_timer: 10-bit high-speed pwm timer with fault front end,
  waveform modes, locked compare update, enhanced resolution, six
  override enables, shared high-byte temporary and compares a, b, c.
  assumes one clock, a synchronous active-high reset, a cpu that
  strobes reads and writes for one cycle each, and fault and
  comparator inputs that are asynchronous to clk_sys_i.
*/
//
// Behaviour
// - fault irq enable lets flag request interrupt
// - fault mode enable lets faults kill waveforms
// - noise filter needs four equal samples
// - edge select: zero falling, one rising
// - comparator source feeds same front end
// - flag set always; cleared by vector or write-one
// - irq only with global, enable and flag
// - pwm enable and mode bits pick sequence
// - compare update and overflow at mode point
// - lock buffers compare writes until cleared
// - enhanced adds bit; lsb picks match edge
// - six-output mode: override enables pick pin source
// - enables map a, not a, b, not b, d, not d; both d pins driven low when enabled
// - 10-bit up/down counter, delayed cpu write
// - counter counts up after any write
// - counter usable as plain 8-bit counter
// - shared temp holds bits nine and eight
// - temp bit two extra msb; rest zero
// - match only when counting onto value
// - match flag set after sync delay
// - compare c match clears counter; dual slope turns it down instead
// - top written below three stored as three
`timescale 1ns/10ps
module hspt_timer (
  input  wire logic                        clk_sys_i,
  input  wire logic                        reset_i,
  input  wire logic [hspt_pkg::ADR_W-1:0]  reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [7:0]                  reg_wdata_i,
  output logic      [7:0]                  reg_rdata_o,
  input  wire logic                        fault_input_pin_i,
  input  wire logic                        comparator_out_i,
  input  wire logic                        channel_pwm_enable_i,
  input  wire logic                        global_irq_enable_i,
  input  wire logic                        fault_vector_taken_i,
  input  wire logic [5:0]                  port_value_i,
  output logic      [5:0]                  pin_out_o,
  output logic                             fault_irq_o
);
  // control registers
  logic [7:0]                  ctrl_d;       // fault and waveform control
  logic [7:0]                  ctrl_e;       // lock and override control
  logic [2:0]                  high_bits_temp; // shared temp
  logic [hspt_pkg::CNT_W-1:0]  counter_value;
  hspt_pkg::hspt_dir_t         dir;          // counting direction
  logic [hspt_pkg::CMP_W-1:0]  buf_a;        // buffered compares
  logic [hspt_pkg::CMP_W-1:0]  buf_b;
  logic [hspt_pkg::CNT_W-1:0]  buf_c;
  logic [hspt_pkg::CMP_W-1:0]  compare_a_value; // active compares
  logic [hspt_pkg::CMP_W-1:0]  compare_b_value;
  logic [hspt_pkg::CNT_W-1:0]  top_compare_value;
  logic                        cnt_wr_pend;  // delayed counter write
  logic [hspt_pkg::CNT_W-1:0]  cnt_wr_val;
  logic                        counted;      // last change was a count
  logic                        match_a_flag;
  logic                        match_b_flag;
  logic                        overflow_flag;
  logic                        hit_a_d;      // sync stage of matches
  logic                        hit_b_d;
  logic                        late_a;       // enhanced late-edge match
  logic                        late_b;
  logic                        wave_a;
  logic                        wave_b;
  logic                        flag_clr_pend; // write-one clear, delayed

  // fault front end
  logic [2:0]                  pin_sync;     // three-stage pin sampler
  logic [2:0]                  cmp_sync;     // three-stage comp sampler
  logic                        pin_lvl;      // agreed pin level
  logic                        cmp_lvl;      // agreed comparator level
  logic [3:0]                  filt_hist;    // last four samples
  logic                        filt_out;
  logic                        front_prev;

  // decode
  logic                        wr_en;
  logic                        dual_slope;
  logic                        six_out_mode;
  logic                        top_hit;
  logic                        bottom_hit;
  logic                        update_pt;
  logic                        ovf_pt;
  logic                        front_raw;
  logic                        front_lvl;
  logic                        fault_event;
  logic                        fault_kill;
  logic                        hit_a;
  logic                        hit_b;
  logic [hspt_pkg::CMP_W-1:0]  wide_wdata;
  logic [hspt_pkg::CNT_W-1:0]  next_top;

  // compare against counter, halved when enhanced
  function automatic logic cmp_hit(
    input logic [hspt_pkg::CMP_W-1:0] cmp,
    input logic [hspt_pkg::CNT_W-1:0] cnt,
    input logic                       enh
  );
    logic [hspt_pkg::CNT_W-1:0] v;
    v = enh ? cmp[hspt_pkg::CMP_W-1:1] : cmp[hspt_pkg::CNT_W-1:0];
    return v == cnt;
  endfunction

  assign wr_en       = reg_wr_i;
  // high bits of any wide write come from the shared temp
  assign wide_wdata  = {high_bits_temp, reg_wdata_i};
  assign dual_slope  = channel_pwm_enable_i
                       & ctrl_d[hspt_pkg::B_WGM_LO];
  assign six_out_mode = channel_pwm_enable_i
                       & ctrl_d[hspt_pkg::B_WGM_HI];
  assign top_hit     = (dir == hspt_pkg::DIR_UP)
                       & (counter_value == top_compare_value);
  assign bottom_hit  = (dir == hspt_pkg::DIR_DOWN)
                       & (counter_value == hspt_pkg::CNT_BOT);
  // normal mode loads at once, otherwise at top or bottom
  assign update_pt   = ~channel_pwm_enable_i
                       | (dual_slope ? bottom_hit : top_hit);
  assign ovf_pt      = dual_slope ? bottom_hit : top_hit;

  // top clamp, values below three become three
  assign next_top = (wide_wdata[hspt_pkg::CNT_W-1:0] < hspt_pkg::TOP_MIN)
                    ? hspt_pkg::TOP_MIN
                    : wide_wdata[hspt_pkg::CNT_W-1:0];

  // input samplers; only stages two and three are looked at
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_sync <= 3'h0;
      cmp_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], fault_input_pin_i};
      cmp_sync <= {cmp_sync[1:0], comparator_out_i};
    end
  end

  // agreed level: changes only when stages two and three match
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_lvl <= 1'b0;
      cmp_lvl <= 1'b0;
    end else begin
      if (pin_sync[1] == pin_sync[2]) begin
        pin_lvl <= pin_sync[2];
      end
      if (cmp_sync[1] == cmp_sync[2]) begin
        cmp_lvl <= cmp_sync[2];
      end
    end
  end

  // comparator replaces the pin when selected
  assign front_raw = ctrl_d[hspt_pkg::B_FCOMP] ? cmp_lvl : pin_lvl;

  // noise filter: output follows only four equal samples
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      filt_hist <= 4'h0;
      filt_out  <= 1'b0;
    end else begin
      filt_hist <= {filt_hist[2:0], front_raw};
      if (filt_hist == hspt_pkg::FILT_ALL) begin
        filt_out <= 1'b1;
      end else if (filt_hist == 4'h0) begin
        filt_out <= 1'b0;
      end
    end
  end

  // filter bypassed when disabled; costs five cycles when on
  assign front_lvl = ctrl_d[hspt_pkg::B_FNOISE] ? filt_out : front_raw;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      front_prev <= 1'b0;
    end else begin
      front_prev <= front_lvl;
    end
  end

  // edge select, pin direction plays no part
  assign fault_event = ctrl_d[hspt_pkg::B_FEDGE]
                       ? (front_lvl & ~front_prev)
                       : (~front_lvl & front_prev);

  // waveforms are forced low while a fault stands in fault mode
  assign fault_kill = ctrl_d[hspt_pkg::B_FMODE]
                      & ctrl_d[hspt_pkg::B_FFLAG];

  // write-one clear of the fault flag lands a cycle later
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flag_clr_pend <= 1'b0;
    end else begin
      flag_clr_pend <= wr_en & (reg_addr_i == hspt_pkg::ADR_CTRL_D)
                       & reg_wdata_i[hspt_pkg::B_FFLAG];
    end
  end

  // control d; fault flag set wins over any clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_d <= hspt_pkg::CTRL_RST;
    end else begin
      if (wr_en && reg_addr_i == hspt_pkg::ADR_CTRL_D) begin
        ctrl_d[7:3] <= reg_wdata_i[7:3];
        ctrl_d[1:0] <= reg_wdata_i[1:0];
      end
      if (fault_event) begin
        ctrl_d[hspt_pkg::B_FFLAG] <= 1'b1;
      end else if (flag_clr_pend || fault_vector_taken_i) begin
        ctrl_d[hspt_pkg::B_FFLAG] <= 1'b0;
      end
    end
  end

  // control e: lock, enhanced, override enables
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_e <= hspt_pkg::CTRL_RST;
    end else if (wr_en && reg_addr_i == hspt_pkg::ADR_CTRL_E) begin
      ctrl_e <= reg_wdata_i;
    end
  end

  // shared temp: cpu writes it, low-byte reads refill it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      high_bits_temp <= 3'h0;
    end else if (wr_en && reg_addr_i == hspt_pkg::ADR_HTMP) begin
      high_bits_temp <= reg_wdata_i[2:0];
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        hspt_pkg::ADR_CNT:  high_bits_temp <= {1'b0, counter_value[9:8]};
        hspt_pkg::ADR_CMPA: high_bits_temp <= buf_a[10:8];
        hspt_pkg::ADR_CMPB: high_bits_temp <= buf_b[10:8];
        hspt_pkg::ADR_CMPC: high_bits_temp <= {1'b0, buf_c[9:8]};
        default:            high_bits_temp <= high_bits_temp;
      endcase
    end
  end

  // counter write waits a cycle, standing in for cpu sync
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_wr_pend <= 1'b0;
      cnt_wr_val  <= hspt_pkg::CNT_RST;
    end else begin
      cnt_wr_pend <= wr_en & (reg_addr_i == hspt_pkg::ADR_CNT);
      cnt_wr_val  <= wide_wdata[hspt_pkg::CNT_W-1:0];
    end
  end

  // counting sequence
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      counter_value <= hspt_pkg::CNT_RST;
      dir           <= hspt_pkg::DIR_UP;
      counted       <= 1'b0;
    end else if (cnt_wr_pend) begin
      counter_value <= cnt_wr_val;
      dir           <= hspt_pkg::DIR_UP;
      counted       <= 1'b0;
    end else begin
      counted <= 1'b1;
      unique case (dir)
        hspt_pkg::DIR_UP: begin
          if (top_hit && dual_slope) begin
            dir           <= hspt_pkg::DIR_DOWN;
            counter_value <= counter_value - hspt_pkg::CNT_ONE;
          end else if (top_hit) begin
            counter_value <= hspt_pkg::CNT_BOT;
          end else begin
            counter_value <= counter_value + hspt_pkg::CNT_ONE;
          end
        end
        hspt_pkg::DIR_DOWN: begin
          if (bottom_hit) begin
            dir           <= hspt_pkg::DIR_UP;
            counter_value <= counter_value + hspt_pkg::CNT_ONE;
          end else begin
            counter_value <= counter_value - hspt_pkg::CNT_ONE;
          end
        end
      endcase
    end
  end

  // compare buffers take every cpu write
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      buf_a <= hspt_pkg::CMP_RST;
      buf_b <= hspt_pkg::CMP_RST;
      buf_c <= hspt_pkg::TOP_RST;
    end else if (wr_en) begin
      if (reg_addr_i == hspt_pkg::ADR_CMPA) begin
        buf_a <= wide_wdata;
      end
      if (reg_addr_i == hspt_pkg::ADR_CMPB) begin
        buf_b <= wide_wdata;
      end
      if (reg_addr_i == hspt_pkg::ADR_CMPC) begin
        buf_c <= next_top;
      end
    end
  end

  // active compares follow buffers at the update point unless locked
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      compare_a_value   <= hspt_pkg::CMP_RST;
      compare_b_value   <= hspt_pkg::CMP_RST;
      top_compare_value <= hspt_pkg::TOP_RST;
    end else if (!ctrl_e[hspt_pkg::B_LOCK] && update_pt) begin
      compare_a_value   <= buf_a;
      compare_b_value   <= buf_b;
      top_compare_value <= buf_c;
    end
  end

  // match only on a counted step, never on a counter write
  assign hit_a = counted & cmp_hit(compare_a_value, counter_value,
                                   ctrl_e[hspt_pkg::B_ENH]);
  assign hit_b = counted & cmp_hit(compare_b_value, counter_value,
                                   ctrl_e[hspt_pkg::B_ENH]);

  // enhanced lsb one moves the match to the later edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      late_a  <= 1'b0;
      late_b  <= 1'b0;
      hit_a_d <= 1'b0;
      hit_b_d <= 1'b0;
    end else begin
      late_a  <= hit_a & ctrl_e[hspt_pkg::B_ENH]
                 & compare_a_value[0];
      late_b  <= hit_b & ctrl_e[hspt_pkg::B_ENH]
                 & compare_b_value[0];
      hit_a_d <= (hit_a & ~(ctrl_e[hspt_pkg::B_ENH]
                 & compare_a_value[0])) | late_a;
      hit_b_d <= (hit_b & ~(ctrl_e[hspt_pkg::B_ENH]
                 & compare_b_value[0])) | late_b;
    end
  end

  // match and overflow flags, write one clears, set wins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      match_a_flag  <= 1'b0;
      match_b_flag  <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (hit_a_d) begin
        match_a_flag <= 1'b1;
      end else if (wr_en && reg_addr_i == hspt_pkg::ADR_FLAGS
                   && reg_wdata_i[hspt_pkg::B_MA]) begin
        match_a_flag <= 1'b0;
      end
      if (hit_b_d) begin
        match_b_flag <= 1'b1;
      end else if (wr_en && reg_addr_i == hspt_pkg::ADR_FLAGS
                   && reg_wdata_i[hspt_pkg::B_MB]) begin
        match_b_flag <= 1'b0;
      end
      if (ovf_pt && !cnt_wr_pend) begin
        overflow_flag <= 1'b1;
      end else if (wr_en && reg_addr_i == hspt_pkg::ADR_FLAGS
                   && reg_wdata_i[hspt_pkg::B_OVF]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // waveforms: set at bottom, clear on match; dual slope mirrors
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end else if (fault_kill) begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end else if (dual_slope) begin
      if (hit_a_d) begin
        wave_a <= (dir == hspt_pkg::DIR_DOWN);
      end
      if (hit_b_d) begin
        wave_b <= (dir == hspt_pkg::DIR_DOWN);
      end
    end else begin
      if (hit_a_d) begin
        wave_a <= 1'b0;
      end else if (top_hit) begin
        wave_a <= 1'b1;
      end
      if (hit_b_d) begin
        wave_b <= 1'b0;
      end else if (top_hit) begin
        wave_b <= 1'b1;
      end
    end
  end

  // pins: override enables pick wave or port in six-output mode
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_out_o <= 6'h00;
    end else if (six_out_mode) begin
      // d channel has no compare here, so its waves stay low
      pin_out_o[0] <= ctrl_e[0] ? wave_a  : port_value_i[0];
      pin_out_o[1] <= ctrl_e[1] ? ~wave_a : port_value_i[1];
      pin_out_o[2] <= ctrl_e[2] ? wave_b  : port_value_i[2];
      pin_out_o[3] <= ctrl_e[3] ? ~wave_b : port_value_i[3];
      pin_out_o[4] <= ctrl_e[4] ? 1'b0    : port_value_i[4];
      pin_out_o[5] <= ctrl_e[5] ? 1'b0    : port_value_i[5];
    end else if (channel_pwm_enable_i) begin
      pin_out_o <= {port_value_i[5:4], ~wave_b, wave_b, ~wave_a, wave_a};
    end else begin
      pin_out_o <= port_value_i;
    end
  end

  // interrupt needs global enable, fault enable and flag
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fault_irq_o <= 1'b0;
    end else begin
      fault_irq_o <= global_irq_enable_i
                     & ctrl_d[hspt_pkg::B_FIRQ_EN]
                     & ctrl_d[hspt_pkg::B_FFLAG];
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        hspt_pkg::ADR_CTRL_D: reg_rdata_o <= ctrl_d;
        hspt_pkg::ADR_CTRL_E: reg_rdata_o <= ctrl_e;
        hspt_pkg::ADR_CNT:    reg_rdata_o <= counter_value[7:0];
        hspt_pkg::ADR_HTMP:   reg_rdata_o <= {5'h00, high_bits_temp};
        hspt_pkg::ADR_CMPA:   reg_rdata_o <= buf_a[7:0];
        hspt_pkg::ADR_CMPB:   reg_rdata_o <= buf_b[7:0];
        hspt_pkg::ADR_CMPC:   reg_rdata_o <= buf_c[7:0];
        hspt_pkg::ADR_FLAGS:  reg_rdata_o <= {5'h00, match_a_flag,
                                              match_b_flag, overflow_flag};
      endcase
    end
  end
endmodule

// ===== testbench/hspt_checker.sv
/*
  hspt_checker: port-level assertions for hspt_timer.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module hspt_checker (
  input wire logic                       clk_sys_i,
  input wire logic                       reset_i,
  input wire logic [hspt_pkg::ADR_W-1:0] reg_addr_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [7:0]                 reg_wdata_i,
  input wire logic [7:0]                 reg_rdata_o,
  input wire logic                       fault_input_pin_i,
  input wire logic                       comparator_out_i,
  input wire logic                       channel_pwm_enable_i,
  input wire logic                       global_irq_enable_i,
  input wire logic                       fault_vector_taken_i,
  input wire logic [5:0]                 port_value_i,
  input wire logic [5:0]                 pin_out_o,
  input wire logic                       fault_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // cycles both fault sources held still; no edge can be in flight
  logic [3:0] quiet;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || $changed(fault_input_pin_i) || $changed(comparator_out_i))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  hold_rdata_a: assert property (
    !$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("rdata moved");
  temp_zero_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == hspt_pkg::ADR_HTMP
    |-> reg_rdata_o[7:3] == 5'h00) else $error("temp upper bits set");
  temp_back_a: assert property (
    $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == hspt_pkg::ADR_HTMP &&
    $past(reg_rd_i) && $past(reg_addr_i) == hspt_pkg::ADR_HTMP
    |-> reg_rdata_o == {5'h00, $past(reg_wdata_i[2:0], 2)})
    else $error("temp readback wrong");
  cnt_hi_a: assert property (
    $past(reg_rd_i, 2) && $past(reg_addr_i, 2) == hspt_pkg::ADR_CNT &&
    $past(reg_rd_i) && $past(reg_addr_i) == hspt_pkg::ADR_HTMP
    |-> !reg_rdata_o[2]) else $error("counter extra bit set");
  irq_gate_a: assert property (
    !$past(global_irq_enable_i) |-> !fault_irq_o)
    else $error("irq without global enable");
  port_pins_a: assert property (
    !$past(reset_i, 2) && !$past(channel_pwm_enable_i, 2) &&
    !$past(channel_pwm_enable_i) |-> pin_out_o == $past(port_value_i))
    else $error("normal mode pins not port");
  vec_clear_a: assert property (
    fault_vector_taken_i && quiet == 4'hf |-> ##3 !fault_irq_o)
    else $error("vector did not clear irq");
  wr_clear_a: assert property (
    reg_wr_i && reg_addr_i == hspt_pkg::ADR_CTRL_D && reg_wdata_i[2] &&
    quiet == 4'hf |-> ##3 !fault_irq_o [*2]) else $error("write-one failed");
endmodule
bind hspt_timer hspt_checker hspt_checker_inst (.*);

// ===== testbench/hspt_power_stage.sv
/*
  hspt_power_stage: power stage model behind the six pins; counts
  switch-on edges of the A gate. assumes gates sampled on clk_sys_i.
*/
`timescale 1ns/10ps
module hspt_power_stage (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [5:0]  gate_i,
  output logic      [15:0] a_edges_o
);
  logic [5:0] gate_q; // last gate state
  // edge counter; a real stage only sees levels, so edges are the proof
  always_ff @(posedge clk_sys_i) begin
    gate_q <= gate_i;
    if (reset_i)
      a_edges_o <= 16'h0000;
    else if (gate_i[0] && !gate_q[0])
      a_edges_o <= a_edges_o + 16'h0001;
  end
endmodule

// ===== testbench/testbench.sv
/*
  testbench: drives hspt_timer through its register port and fault
  inputs. assumes the checker is bound and the power stage model.
*/
`timescale 1ns/10ps
module testbench;
  logic        clk_sys_i, reset_i, reg_wr_i, reg_rd_i, fault_irq_o;
  logic        fault_input_pin_i, comparator_out_i, channel_pwm_enable_i;
  logic        global_irq_enable_i, fault_vector_taken_i;
  logic [2:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, lo;
  logic [5:0]  port_value_i, pin_out_o;
  logic [15:0] a_edges;
  int          miscompares, samples_checked;
  // fault cases: control, source (1 comparator), width, readback
  localparam logic [31:0] F_CASE [6] = '{32'h1000_0814, 32'h0000_0804,
    32'h3000_0230, 32'h3000_0834, 32'h1801_081c, 32'h1001_0810};
  hspt_timer hspt_timer_inst (.*);
  hspt_power_stage hspt_power_stage_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .gate_i(pin_out_o), .a_edges_o(a_edges));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = !clk_sys_i;
  end
  // one register cycle, launched at a falling edge
  task automatic bus(logic [2:0] a, logic w, logic r, logic [7:0] d);
    reg_addr_i = a;
    reg_wr_i = w;
    reg_rd_i = r;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
  endtask
  task automatic cyc(int n);
    repeat (n) bus(3'h0, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic check(logic [7:0] g, logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    bus(a, 1'b0, 1'b1, 8'h00);
    check(reg_rdata_o, e);
  endtask
  // pulse on pin or comparator, then let the front end settle
  task automatic pulse(logic s, int w);
    if (s)
      comparator_out_i = 1'b1;
    else
      fault_input_pin_i = 1'b1;
    cyc(w);
    comparator_out_i = 1'b0;
    fault_input_pin_i = 1'b0;
    cyc(20);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {reset_i, reg_wr_i, reg_rd_i, fault_input_pin_i} = 4'h8;
    {comparator_out_i, channel_pwm_enable_i} = 2'b00;
    {global_irq_enable_i, fault_vector_taken_i} = 2'b00;
    {reg_addr_i, reg_wdata_i, port_value_i} = {11'h000, 6'h2a};
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
    cyc(3);
    check({2'b00, pin_out_o}, 8'h2a);
    bus(hspt_pkg::ADR_HTMP, 1'b1, 1'b0, 8'hff);
    rd(hspt_pkg::ADR_HTMP, 8'h07);
    bus(hspt_pkg::ADR_CMPC, 1'b1, 1'b0, 8'hff);
    bus(hspt_pkg::ADR_HTMP, 1'b1, 1'b0, 8'h02);
    bus(hspt_pkg::ADR_CNT, 1'b1, 1'b0, 8'h10);
    cyc(4);
    bus(hspt_pkg::ADR_CNT, 1'b0, 1'b1, 8'h00);
    lo = reg_rdata_o;
    rd(hspt_pkg::ADR_HTMP, 8'h02);
    check({7'h00, lo >= 8'h10 && lo < 8'h20}, 8'h01);
    bus(hspt_pkg::ADR_HTMP, 1'b1, 1'b0, 8'h00);
    bus(hspt_pkg::ADR_CMPC, 1'b1, 1'b0, 8'h01);
    rd(hspt_pkg::ADR_CMPC, 8'h03);
    for (int i = 0; i < 6; i++) begin
      bus(hspt_pkg::ADR_CTRL_D, 1'b1, 1'b0, F_CASE[i][31:24] | 8'h04);
      cyc(20);
      pulse(F_CASE[i][16], int'(F_CASE[i][15:8]));
      rd(hspt_pkg::ADR_CTRL_D, F_CASE[i][7:0]);
    end
    global_irq_enable_i = 1'b1;
    bus(hspt_pkg::ADR_CTRL_D, 1'b1, 1'b0, 8'h94);
    cyc(20);
    pulse(1'b0, 8);
    check({7'h00, fault_irq_o}, 8'h01);
    fault_vector_taken_i = 1'b1;
    cyc(1);
    fault_vector_taken_i = 1'b0;
    cyc(4);
    check({7'h00, fault_irq_o}, 8'h00);
    global_irq_enable_i = 1'b0;
    pulse(1'b0, 8);
    check({7'h00, fault_irq_o}, 8'h00);
    global_irq_enable_i = 1'b1;
    cyc(3);
    check({7'h00, fault_irq_o}, 8'h01);
    bus(hspt_pkg::ADR_CTRL_D, 1'b1, 1'b0, 8'h94);
    cyc(4);
    check({7'h00, fault_irq_o}, 8'h00);
    bus(hspt_pkg::ADR_CMPC, 1'b1, 1'b0, 8'h20);
    bus(hspt_pkg::ADR_CMPA, 1'b1, 1'b0, 8'h10);
    bus(hspt_pkg::ADR_FLAGS, 1'b1, 1'b0, 8'h07);
    bus(hspt_pkg::ADR_CNT, 1'b1, 1'b0, 8'h00);
    port_value_i = 6'h3f;
    channel_pwm_enable_i = 1'b1;
    bus(hspt_pkg::ADR_CTRL_D, 1'b1, 1'b0, 8'h02);
    bus(hspt_pkg::ADR_CTRL_E, 1'b1, 1'b0, 8'h00);
    cyc(3);
    check({2'b00, pin_out_o}, 8'h3f);
    bus(hspt_pkg::ADR_CTRL_E, 1'b1, 1'b0, 8'h3f);
    cyc(200);
    check({6'h00, pin_out_o[5:4]}, 8'h00);
    check({7'h00, a_edges > 16'h0003}, 8'h01);
    bus(hspt_pkg::ADR_FLAGS, 1'b0, 1'b1, 8'h00);
    check(reg_rdata_o & 8'h05, 8'h05);
    bus(hspt_pkg::ADR_CTRL_D, 1'b1, 1'b0, 8'h42);
    pulse(1'b0, 8);
    check({2'b00, pin_out_o}, 8'h0a);
    print_verdict();
  end
  // hang guard, well past the roughly 650 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    miscompares++;
    print_verdict();
  end
endmodule
